//--- hdl/plcs_pkg.sv
// Constants, register map and carrier types of the clock synthesis control block
package plcs_pkg;

  // ********************************************************************
  // Register map (byte addresses on the APB)
  // ********************************************************************
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] DIV_OFS    = 12'h004;
  localparam logic [11:0] DLY_OFS    = 12'h008;
  localparam logic [11:0] STAT_OFS   = 12'h00C;

  // Control register fields
  localparam int CTRL_DYN_BIT  = 0;
  localparam int CTRL_WOL_BIT  = 1;
  localparam int CTRL_RED_BIT  = 2;

  // Divider register fields
  localparam int DIV_IN_LSB    = 0;
  localparam int DIV_FB_LSB    = 4;
  localparam int DIV_OUT_LSB   = 8;
  localparam int DIV_LOW_LSB   = 16;

  // Delay and phase register fields
  localparam int DLY_STEP_LSB  = 0;
  localparam int DLY_PHASE_LSB = 8;
  localparam int DLY_DUTY_LSB  = 12;

  // Status register fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  localparam int STAT_REFV_BIT = 2;
  localparam int STAT_FBV_BIT  = 3;
  localparam int STAT_ZR_BIT   = 4;
  localparam int STAT_LAG_BIT  = 5;
  localparam int STAT_STEP_LSB = 8;
  localparam int STAT_PER_LSB  = 16;

  // ********************************************************************
  // Limits and reset values
  // ********************************************************************
  localparam logic [3:0] IN_DIV_MIN   = 4'h1;
  localparam logic [3:0] IN_DIV_MAX   = 4'hC;
  localparam logic [4:0] OUT_DIV_MIN  = 5'h02;
  localparam logic [4:0] OUT_DIV_MAX  = 5'h18;
  localparam logic [7:0] LOW_DIV_MIN  = 8'h02;
  localparam logic [7:0] LOW_DIV_MAX  = 8'h80;
  localparam logic [4:0] STEP_MAX     = 5'h08;
  localparam logic [4:0] STEP_MIN     = 5'h18;
  localparam logic [2:0] DUTY_MIN     = 3'h1;
  localparam logic [2:0] DUTY_RST     = 3'h4;
  localparam logic [2:0] PHASE_RST    = 3'h0;
  localparam logic [4:0] STEP_RST     = 5'h00;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  localparam logic [15:0] VCO_PER_RST = 16'h0008;
  localparam logic [15:0] VCO_PER_MAX = 16'hFFFF;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int DELAY_STEP_PS  = 250;
  localparam int DELAY_TOTAL_PS = 2000;
  localparam int DELAY_STEPS    = DELAY_TOTAL_PS / DELAY_STEP_PS;
  localparam int DLINE_LEN      = 2 * DELAY_STEPS + 1;
  localparam logic [4:0] DLY_CENTER = 5'h08;
  localparam int CLK_LOSS_NS    = 4000;
  localparam int CLK_LOSS_CYC   = (CLK_LOSS_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOSS_W         = 10;
  localparam logic [4:0] LOCK_MATCHES = 5'h10;

  // ********************************************************************
  // Carrier types
  // ********************************************************************
  typedef struct packed {
    logic [7:0] low_div;
    logic [4:0] out_div;
    logic [3:0] fb_div;
    logic [3:0] in_div;
  } plcs_div_t;

  typedef struct packed {
    logic       zero;
    logic       lag;
    logic [2:0] step;
  } plcs_dly_t;

  typedef enum logic [1:0] {
    PLCS_ACQUIRE = 2'b01,
    PLCS_LOCKED  = 2'b10
  } plcs_lock_t;

endpackage

//--- hdl/plcs_top.sv
// Clock synthesis loop model with dividers, delay adjust and lock detect
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module plcs_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        reference_clock_in,
  input  wire logic        feedback_clock_in,
  input  wire logic        pll_reset_in,
  input  wire logic        dyn_delay_select,
  input  wire logic        dyn_delay_zero_in,
  input  wire logic        dyn_delay_lag_in,
  input  wire logic [2:0]  dyn_delay_step_in,
  output var  logic        main_clock_out,
  output var  logic        shifted_clock_out,
  output var  logic        low_clock_out,
  output var  logic        lock_out,
  output var  logic        wake_out,
  output var  logic        dyn_delay_zero_out,
  output var  logic        dyn_delay_lag_out,
  output var  logic [2:0]  dyn_delay_step_out
);

  // ********************************************************************
  // Configuration registers and APB slave
  // ********************************************************************
  logic [2:0]        ctrl_reg;
  plcs_pkg::plcs_div_t div_reg;
  logic [4:0]        steps_reg;
  logic [2:0]        phase_reg;
  logic [2:0]        duty_reg;
  logic [31:0]       read_word;
  logic              sel_ctrl;
  logic              sel_div;
  logic              sel_dly;
  logic              sel_stat;
  logic              addr_ok;
  logic              setup_ph;
  logic              wr_en;

  // Address decode and phase qualifiers
  assign sel_ctrl = (paddr == plcs_pkg::CTRL_OFS);
  assign sel_div  = (paddr == plcs_pkg::DIV_OFS);
  assign sel_dly  = (paddr == plcs_pkg::DLY_OFS);
  assign sel_stat = (paddr == plcs_pkg::STAT_OFS);
  assign addr_ok  = sel_ctrl | sel_div | sel_dly | sel_stat;
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pready & pwrite & addr_ok;

  // Clamp helpers so an illegal write never stalls a divider
  function automatic logic [3:0] clamp_div12(input logic [3:0] v);
    clamp_div12 = (v < plcs_pkg::IN_DIV_MIN) ? plcs_pkg::IN_DIV_MIN :
                  (v > plcs_pkg::IN_DIV_MAX) ? plcs_pkg::IN_DIV_MAX : v;
  endfunction

  function automatic logic [4:0] clamp_out(input logic [4:0] v);
    clamp_out = (v < plcs_pkg::OUT_DIV_MIN) ? plcs_pkg::OUT_DIV_MIN :
                (v > plcs_pkg::OUT_DIV_MAX) ? plcs_pkg::OUT_DIV_MAX : {v[4:1], 1'b0};
  endfunction

  function automatic logic [7:0] clamp_low(input logic [7:0] v);
    clamp_low = (v < plcs_pkg::LOW_DIV_MIN) ? plcs_pkg::LOW_DIV_MIN :
                (v > plcs_pkg::LOW_DIV_MAX) ? plcs_pkg::LOW_DIV_MAX : {v[7:1], 1'b0};
  endfunction

  function automatic logic [4:0] clamp_step(input logic [4:0] v);
    clamp_step = (!v[4] && v > plcs_pkg::STEP_MAX) ? plcs_pkg::STEP_MAX :
                 (v[4] && v < plcs_pkg::STEP_MIN) ? plcs_pkg::STEP_MIN : v;
  endfunction

  // Configuration writes; divisor values only change here
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg  <= plcs_pkg::CTRL_RST;
      div_reg   <= '{low_div: plcs_pkg::LOW_DIV_MIN, out_div: plcs_pkg::OUT_DIV_MIN,
                     fb_div: plcs_pkg::IN_DIV_MIN, in_div: plcs_pkg::IN_DIV_MIN};
      steps_reg <= plcs_pkg::STEP_RST;
      phase_reg <= plcs_pkg::PHASE_RST;
      duty_reg  <= plcs_pkg::DUTY_RST;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_reg <= pwdata[2:0];
      end
      if (sel_div) begin
        div_reg.in_div  <= clamp_div12(pwdata[plcs_pkg::DIV_IN_LSB +: 4]);
        div_reg.fb_div  <= clamp_div12(pwdata[plcs_pkg::DIV_FB_LSB +: 4]);
        div_reg.out_div <= clamp_out(pwdata[plcs_pkg::DIV_OUT_LSB +: 5]);
        div_reg.low_div <= clamp_low(pwdata[plcs_pkg::DIV_LOW_LSB +: 8]);
      end
      if (sel_dly) begin
        steps_reg <= clamp_step(pwdata[plcs_pkg::DLY_STEP_LSB +: 5]);
        phase_reg <= pwdata[plcs_pkg::DLY_PHASE_LSB +: 3];
        duty_reg  <= (pwdata[plcs_pkg::DLY_DUTY_LSB +: 3] < plcs_pkg::DUTY_MIN) ?
                     plcs_pkg::DUTY_MIN : pwdata[plcs_pkg::DLY_DUTY_LSB +: 3];
      end
    end
  end

  // Read data captured in the setup phase, zero-wait answer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_ph) begin
        prdata  <= (addr_ok && !pwrite) ? read_word : 32'h0000_0000;
        pslverr <= ~addr_ok;
      end
    end
  end

  // ********************************************************************
  // Pin input synchronisers
  // ********************************************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_reg;
  logic [2:0] pin_agree;
  logic [2:0] pin_next;
  logic [2:0] pin_rise;

  // A change counts once stages two and three agree
  assign pin_raw   = {pll_reset_in, feedback_clock_in, reference_clock_in};
  assign pin_agree = ~(sync2_reg ^ sync3_reg);
  assign pin_next  = (pin_agree & sync2_reg) | (~pin_agree & pin_reg);
  assign pin_rise  = pin_next & ~pin_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      pin_reg   <= 3'h0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= pin_next;
    end
  end

  // ********************************************************************
  // Clock presence watchdogs (reference and feedback)
  // ********************************************************************
  logic [1:0] clk_valid;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_watch
      logic [plcs_pkg::LOSS_W-1:0] idle_reg;
      // Counts cycles since the last rising edge, saturating
      always_ff @(posedge clk) begin
        if (!nrst) begin
          idle_reg <= plcs_pkg::LOSS_W'(plcs_pkg::CLK_LOSS_CYC);
        end else if (pin_rise[gi]) begin
          idle_reg <= '0;
        end else if (idle_reg < plcs_pkg::LOSS_W'(plcs_pkg::CLK_LOSS_CYC)) begin
          idle_reg <= idle_reg + 1'b1;
        end
      end
      assign clk_valid[gi] = idle_reg < plcs_pkg::LOSS_W'(plcs_pkg::CLK_LOSS_CYC);
    end
  endgenerate

  // ********************************************************************
  // Input and feedback dividers
  // ********************************************************************
  logic       reduced;
  logic       rst_hold;
  logic [3:0] in_cnt_reg;
  logic [3:0] fb_cnt_reg;
  logic       ref_tick;
  logic       fb_tick;

  // Reduced variant has no reset pin; divisor one ignores reset
  assign reduced  = ctrl_reg[plcs_pkg::CTRL_RED_BIT];
  assign rst_hold = pin_reg[2] & ~reduced & (div_reg.in_div != plcs_pkg::IN_DIV_MIN);
  assign ref_tick = pin_rise[0] & ~rst_hold &
                    (in_cnt_reg >= 4'(div_reg.in_div - 4'h1));
  assign fb_tick  = pin_rise[1] & (fb_cnt_reg >= 4'(div_reg.fb_div - 4'h1));

  // Reset only zeroes the phase counter, never the divisor
  always_ff @(posedge clk) begin
    if (!nrst || rst_hold) begin
      in_cnt_reg <= 4'h0;
    end else if (pin_rise[0]) begin
      in_cnt_reg <= ref_tick ? 4'h0 : in_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fb_cnt_reg <= 4'h0;
    end else if (pin_rise[1]) begin
      fb_cnt_reg <= fb_tick ? 4'h0 : fb_cnt_reg + 4'h1;
    end
  end

  // ********************************************************************
  // Phase comparison and oscillator tuning
  // ********************************************************************
  logic [1:0]  fb_seen_reg;
  logic [15:0] vco_per_reg;
  logic [15:0] vco_cnt_reg;
  logic        vco_tick;
  logic        match;

  assign match    = ref_tick & (fb_seen_reg == 2'h1);
  assign vco_tick = (vco_cnt_reg >= 16'(vco_per_reg - 16'h0001));

  // Feedback ticks counted between divided reference ticks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fb_seen_reg <= 2'h0;
    end else if (ref_tick) begin
      fb_seen_reg <= {1'b0, fb_tick};
    end else if (fb_tick && fb_seen_reg != 2'h2) begin
      fb_seen_reg <= fb_seen_reg + 2'h1;
    end
  end

  // Too few feedback ticks speeds the oscillator, too many slows it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vco_per_reg <= plcs_pkg::VCO_PER_RST;
    end else if (ref_tick && !match) begin
      if (fb_seen_reg == 2'h0 && vco_per_reg > 16'h0001) begin
        vco_per_reg <= vco_per_reg - 16'h0001;
      end else if (fb_seen_reg != 2'h0 && vco_per_reg != plcs_pkg::VCO_PER_MAX) begin
        vco_per_reg <= vco_per_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || vco_tick) begin
      vco_cnt_reg <= 16'h0000;
    end else begin
      vco_cnt_reg <= vco_cnt_reg + 16'h0001;
    end
  end

  // ********************************************************************
  // Output dividers and shifted output
  // ********************************************************************
  logic [3:0]  out_cnt_reg;
  logic        main_pre_reg;
  logic        main_toggle;
  logic        main_rise;
  logic [6:0]  low_cnt_reg;
  logic        low_pre_reg;
  logic        low_toggle;
  logic [15:0] main_cyc_reg;
  logic [15:0] main_per_reg;
  logic [12:0] eighth_len;
  logic [12:0] eighth_cnt_reg;
  logic [2:0]  octant_reg;
  logic        shifted_pre;

  // Main toggles every half divisor oscillator ticks
  assign main_toggle = vco_tick & (out_cnt_reg >= 4'(div_reg.out_div[4:1] - 4'h1));
  assign main_rise   = main_toggle & ~main_pre_reg;
  assign low_toggle  = main_rise & (low_cnt_reg >= 7'(div_reg.low_div[7:1] - 7'h01));
  assign eighth_len  = (main_per_reg[15:3] == 13'h0000) ? 13'h0001 : main_per_reg[15:3];
  assign shifted_pre = (3'(octant_reg - phase_reg) < duty_reg);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_cnt_reg  <= 4'h0;
      main_pre_reg <= 1'b0;
    end else if (vco_tick) begin
      out_cnt_reg  <= main_toggle ? 4'h0 : out_cnt_reg + 4'h1;
      main_pre_reg <= main_pre_reg ^ main_toggle;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_cnt_reg <= 7'h00;
      low_pre_reg <= 1'b0;
    end else if (main_rise) begin
      low_cnt_reg <= low_toggle ? 7'h00 : low_cnt_reg + 7'h01;
      low_pre_reg <= low_pre_reg ^ low_toggle;
    end
  end

  // Main period measured so the shifted output can split it in eighths
  always_ff @(posedge clk) begin
    if (!nrst) begin
      main_cyc_reg   <= 16'h0000;
      main_per_reg   <= 16'h0000;
      eighth_cnt_reg <= 13'h0000;
      octant_reg     <= 3'h0;
    end else if (main_rise) begin
      main_cyc_reg   <= 16'h0000;
      main_per_reg   <= 16'(main_cyc_reg + 16'h0001);
      eighth_cnt_reg <= 13'h0000;
      octant_reg     <= 3'h0;
    end else begin
      main_cyc_reg <= (main_cyc_reg == 16'hFFFF) ? main_cyc_reg : main_cyc_reg + 16'h0001;
      if (eighth_cnt_reg >= 13'(eighth_len - 13'h0001)) begin
        eighth_cnt_reg <= 13'h0000;
        octant_reg     <= (octant_reg == 3'h7) ? octant_reg : octant_reg + 3'h1;
      end else begin
        eighth_cnt_reg <= eighth_cnt_reg + 13'h0001;
      end
    end
  end

  // ********************************************************************
  // Delay selection and common delay line
  // ********************************************************************
  logic              dyn_active;
  logic [3:0]        dyn_mag;
  logic [4:0]        dyn_steps;
  logic [4:0]        applied_steps;
  logic [4:0]        abs_steps;
  logic [4:0]        tap;
  plcs_pkg::plcs_dly_t applied_dly;
  logic [2:0]        dline [0:plcs_pkg::DLINE_LEN-1];

  // Dynamic bus only counts when configured dynamic, selected and not reduced
  assign dyn_active = ctrl_reg[plcs_pkg::CTRL_DYN_BIT] & ~reduced & dyn_delay_select;
  assign dyn_mag    = {1'b0, dyn_delay_step_in} + 4'h1;
  assign dyn_steps  = dyn_delay_zero_in ? 5'h00 :
                      dyn_delay_lag_in ? {1'b0, dyn_mag} : 5'(-{1'b0, dyn_mag});
  assign applied_steps = dyn_active ? dyn_steps : steps_reg;
  assign abs_steps  = applied_steps[4] ? 5'(-applied_steps) : applied_steps;
  assign tap        = 5'(applied_steps + plcs_pkg::DLY_CENTER);
  assign applied_dly.zero = (applied_steps == 5'h00);
  assign applied_dly.lag  = ~applied_steps[4] & (applied_steps != 5'h00);
  assign applied_dly.step = applied_dly.zero ? 3'h0 : 3'(abs_steps - 5'h01);

  // One delay line carries main, shifted and low together
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dline[0] <= 3'h0;
    end else begin
      dline[0] <= {low_pre_reg & ~reduced, shifted_pre & ~reduced, main_pre_reg};
    end
  end

  generate
    for (gi = 1; gi < plcs_pkg::DLINE_LEN; gi = gi + 1) begin : g_dline
      always_ff @(posedge clk) begin
        if (!nrst) begin
          dline[gi] <= 3'h0;
        end else begin
          dline[gi] <= dline[gi-1];
        end
      end
    end
  endgenerate

  // Clock outputs taken from the selected tap
  always_ff @(posedge clk) begin
    if (!nrst) begin
      main_clock_out    <= 1'b0;
      shifted_clock_out <= 1'b0;
      low_clock_out     <= 1'b0;
    end else begin
      main_clock_out    <= dline[tap][0];
      shifted_clock_out <= dline[tap][1];
      low_clock_out     <= dline[tap][2];
    end
  end

  // Applied delay read back to fabric, none in reduced variant
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dyn_delay_zero_out <= 1'b0;
      dyn_delay_lag_out  <= 1'b0;
      dyn_delay_step_out <= 3'h0;
    end else begin
      dyn_delay_zero_out <= applied_dly.zero & ~reduced;
      dyn_delay_lag_out  <= applied_dly.lag & ~reduced;
      dyn_delay_step_out <= reduced ? 3'h0 : applied_dly.step;
    end
  end

  // ********************************************************************
  // Lock detection and wake
  // ********************************************************************
  plcs_pkg::plcs_lock_t lock_state_reg;
  plcs_pkg::plcs_lock_t lock_next;
  logic [4:0]         match_cnt_reg;
  logic               clocks_ok;
  logic               settled;

  assign clocks_ok = &clk_valid;
  assign settled   = clocks_ok & ~rst_hold & (match_cnt_reg >= plcs_pkg::LOCK_MATCHES);

  // Consecutive matching comparisons, cleared on any upset
  always_ff @(posedge clk) begin
    if (!nrst || !clocks_ok || rst_hold) begin
      match_cnt_reg <= 5'h00;
    end else if (ref_tick) begin
      match_cnt_reg <= !match ? 5'h00 :
                       (match_cnt_reg == plcs_pkg::LOCK_MATCHES) ? match_cnt_reg :
                       match_cnt_reg + 5'h01;
    end
  end

  // Lock state transitions
  always_comb begin
    lock_next = lock_state_reg;
    unique case (lock_state_reg)
      plcs_pkg::PLCS_ACQUIRE: begin
        if (settled) begin
          lock_next = plcs_pkg::PLCS_LOCKED;
        end
      end
      plcs_pkg::PLCS_LOCKED: begin
        if (!clocks_ok || rst_hold || (ref_tick && !match)) begin
          lock_next = plcs_pkg::PLCS_ACQUIRE;
        end
      end
      default: begin
        lock_next = plcs_pkg::PLCS_ACQUIRE;
      end
    endcase
  end

  // Wake is sticky; with the option on it waits for lock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_state_reg <= plcs_pkg::PLCS_ACQUIRE;
      lock_out       <= 1'b0;
      wake_out       <= 1'b0;
    end else begin
      lock_state_reg <= lock_next;
      lock_out       <= (lock_next == plcs_pkg::PLCS_LOCKED);
      wake_out       <= wake_out | ~ctrl_reg[plcs_pkg::CTRL_WOL_BIT] | lock_out;
    end
  end

  // ********************************************************************
  // Read mux
  // ********************************************************************
  logic [31:0] stat_word;

  assign stat_word = {vco_per_reg, 5'h00, dyn_delay_step_out, 2'h0, dyn_delay_lag_out,
                      dyn_delay_zero_out, clk_valid[1], clk_valid[0], wake_out, lock_out};
  assign read_word = sel_ctrl ? {29'h0000_0000, ctrl_reg} :
                     sel_div  ? {8'h00, div_reg.low_div, 3'h0, div_reg.out_div, div_reg.fb_div,
                                 div_reg.in_div} :
                     sel_dly  ? {17'h0_0000, duty_reg, 1'b0, phase_reg, 3'h0, steps_reg} :
                     sel_stat ? stat_word : 32'h0000_0000;

endmodule // plcs_top

`default_nettype wire

//--- tb/plcs_sva.sv
// Assertion checker of the clock synthesis control block
`timescale 1ns/1ps
`default_nettype none
module plcs_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        pready,
  input wire logic        reference_clock_in,
  input wire logic        lock_out,
  input wire logic        wake_out,
  input wire logic        dyn_delay_zero_out
);
  logic [9:0] idle_reg;
  default clocking dc @(posedge clk);
  endclocking
  // Cycles since the reference last moved
  always_ff @(posedge clk) begin
    if (!nrst || $changed(reference_clock_in)) idle_reg <= 10'h000;
    else if (idle_reg != 10'h3FF) idle_reg <= idle_reg + 10'h001;
  end
  property p_rst_quiet; !nrst |=> !pready && !lock_out; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
  property p_rel_static; $rose(nrst) |=> dyn_delay_zero_out; endproperty
  a_rel_static: assert property (p_rel_static) else $error("no zero delay");
  property p_wake_hold; disable iff (!nrst) wake_out |=> wake_out; endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
  property p_wake_why;
    disable iff (!nrst) $rose(wake_out) |-> !$past(nrst, 2) || lock_out || $past(lock_out);
  endproperty
  a_wake_why: assert property (p_wake_why) else $error("wake without lock");
  property p_ref_loss; disable iff (!nrst) idle_reg >= 10'h208 |-> !lock_out; endproperty
  a_ref_loss: assert property (p_ref_loss) else $error("lock kept");
  property p_lock_why; disable iff (!nrst) $rose(lock_out) |-> idle_reg < 10'h1F4; endproperty
  a_lock_why: assert property (p_lock_why) else $error("lock on idle ref");
  property p_unmap;
    disable iff (!nrst) psel && !penable && paddr[11:4] != 8'h00 |=> pslverr && prdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no slave error");
  property p_map;
    disable iff (!nrst) psel && !penable && paddr < 12'h010 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("bad slave error");
endmodule // plcs_sva
bind plcs_top plcs_sva i_plcs_sva (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .pready(pready),
  .reference_clock_in(reference_clock_in), .lock_out(lock_out), .wake_out(wake_out),
  .dyn_delay_zero_out(dyn_delay_zero_out));
`default_nettype wire

//--- tb/plcs_fabric.sv
// Fabric side model: reference, loop reset, delay bus, feedback
`timescale 1ns/1ps
`default_nettype none
module plcs_fabric (
  input  wire logic       clk,
  input  wire logic       ref_run,
  input  wire logic       rst_req,
  input  wire logic [5:0] dyn_cmd,
  input  wire logic       main_clk,
  output var  logic       ref_clk,
  output var  logic       fb_clk,
  output var  logic       pll_rst,
  output var  logic [5:0] dyn_bus
);
  logic [1:0] div_reg = 2'h0;
  // Reference toggles every fourth cycle, stands low when stopped
  always_ff @(posedge clk) begin
    div_reg <= div_reg + 2'h1;
    ref_clk <= ref_run && (ref_clk ^ (div_reg == 2'h3));
    pll_rst <= rst_req;
    dyn_bus <= dyn_cmd;
  end
  assign fb_clk = main_clk;
endmodule // plcs_fabric
`default_nettype wire

//--- tb/plcs_top_tb.sv
// Self-checking bench of the clock synthesis control block
`timescale 1ns/1ps
`default_nettype none
module plcs_top_tb;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ref_run = 0, rq = 0, err;
  logic [11:0] addr = 0;
  logic [31:0] wd = 0, rd, prdata;
  logic pready, pslverr, refc, fbc, prst, mclk, lock, wake, zo, lo, sco, lco, pm, pl;
  logic [2:0] so;
  logic [5:0] dyn = 0, dbus;
  int num_errors = 0, comparisons = 0, seed = 32'h551b, s, v, n, m, k;
  always #4 clk = !clk;
  plcs_top i_plcs_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(pen), .pwrite(pwr),
    .paddr(addr), .pwdata(wd), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock_in(refc), .feedback_clock_in(fbc), .pll_reset_in(prst),
    .dyn_delay_select(dbus[5]), .dyn_delay_zero_in(dbus[4]), .dyn_delay_lag_in(dbus[3]),
    .dyn_delay_step_in(dbus[2:0]), .main_clock_out(mclk), .shifted_clock_out(sco),
    .low_clock_out(lco), .lock_out(lock), .wake_out(wake), .dyn_delay_zero_out(zo),
    .dyn_delay_lag_out(lo), .dyn_delay_step_out(so));
  plcs_fabric i_plcs_fabric (.clk(clk), .ref_run(ref_run), .rst_req(rq), .dyn_cmd(dyn),
    .main_clk(mclk), .ref_clk(refc), .fb_clk(fbc), .pll_rst(prst), .dyn_bus(dbus));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wt(int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    {psel, pwr, addr, wd} <= {1'b1, w, a, d};
    @(posedge clk) pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
  endtask
  function automatic int cl(int x, int l, int h, bit ev);
    x = x < l ? l : (x > h ? h : x);
    return ev ? x / 2 * 2 : x;
  endfunction
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    wt(1);
    chk("wake", 1, wake);
    chk("zero", 1, zo);
    apb(0, 12'h008, 0);
    chk("dly", 32'h4000, rd);
    apb(0, 12'h010, 0);
    chk("unmapped", 1, {rd[30:0], err});
    for (int i = 0; i < 6; i++) begin
      v = i == 0 ? 0 : (i == 1 ? -1 : $random(seed));
      apb(1, 12'h004, v);
      apb(0, 12'h004, 0);
      chk("div", 32'((cl(v[23:16], 2, 128, 1) << 16) | (cl(v[12:8], 2, 24, 1) << 8) |
        (cl(v[7:4], 1, 12, 0) << 4) | cl(v[3:0], 1, 12, 0)), rd);
    end
    $display("done divisors");
    for (s = -9; s < 10; s++) begin
      apb(1, 12'h008, 32'h4000 | (s & 31));
      v = cl(s, -8, 8, 0);
      apb(0, 12'h008, 0);
      chk("dly", 32'h4000 | (v & 31), rd);
      wt(1);
      chk("zero", v == 0, zo);
      if (v != 0) chk("dir", {v > 0, 3'(v > 0 ? v - 1 : -v - 1)}, {lo, so});
    end
    apb(1, 12'h000, 1);
    for (int i = 0; i < 9; i++) begin
      v = $random(seed);
      @(posedge clk) dyn <= {1'b1, i == 8, v[0], 3'(i)};
      wt(3);
      chk("zero", i == 8, zo);
      if (i < 8) chk("dir", {v[0], 3'(i)}, {lo, so});
    end
    apb(1, 12'h000, 0);
    wt(2);
    chk("ignore", 5'h0F, {zo, lo, so});
    $display("done delay");
    apb(1, 12'h004, 32'h00020211);
    @(posedge clk) ref_run <= 1'b1;
    for (n = 0; n < 3000 && lock !== 1'b1; n++) wt(1);
    chk("lock", 1, lock);
    // Toggle and high counts over 32 main periods of 8 cycles
    m = 0;
    k = 0;
    n = 0;
    {pm, pl} = {mclk, lco};
    repeat (256) begin
      wt(1);
      m += (mclk != pm);
      k += (lco != pl);
      n += sco;
      {pm, pl} = {mclk, lco};
    end
    chk("main", 64, m);
    chk("low", 32, k);
    chk("duty", 128, n);
    @(posedge clk) rq <= 1'b1;
    wt(20);
    chk("lock", 1, lock);
    @(posedge clk) rq <= 1'b0;
    apb(1, 12'h004, 32'h00020212);
    @(posedge clk) rq <= 1'b1;
    wt(20);
    chk("lock", 0, lock);
    @(posedge clk) rq <= 1'b0;
    apb(0, 12'h004, 0);
    chk("div", 32'h00020212, rd);
    for (n = 0; n < 3000 && lock !== 1'b1; n++) wt(1);
    chk("lock", 1, lock);
    @(posedge clk) ref_run <= 1'b0;
    wt(600);
    chk("lock", 0, lock);
    $display("done lock");
    complete_run();
  end
endmodule // plcs_top_tb
`default_nettype wire
